// ### include/nvs_pkg.sv
// Constants, types and timing figures for the nonvolatile SRAM host controller.
// Contract
// - Host holds write strobe high during every SRAM read cycle.
// - Command sequence advances only by reads ended by select or output drive.
// - Host reads six sequence addresses back to back in exact order.
// - Host keeps write strobe high across all six sequence reads.
// - Each sequence read lasts at least one initiation cycle time.
// - Hardware save request is held low for at least 15 ns.
// - Host leaves the save/busy line released during SRAM reads and writes.
package nvs_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int ADDR_W   = 17;
    localparam int DATA_W   = 8;
    localparam int TMR_W    = 24;
    localparam int IDX_W    = 3;
    localparam int SEQ_LEN  = 6;
    localparam logic [IDX_W-1:0] SEQ_FIRST = 3'h0;
    localparam logic [IDX_W-1:0] SEQ_LAST  = 3'h5;

    // ------------------------------------------------------------------
    // Timing in printed units and derived cycle counts
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int T_RC_NS       = 45;
    localparam int T_WP_NS       = 30;
    localparam int T_WC_NS       = 45;
    localparam int T_HSB_NS      = 15;
    localparam int T_SS_US       = 70;
    localparam int T_DELAY_US    = 70;
    localparam int T_RECALL_US   = 100;
    localparam int T_STORE_MS    = 15;
    localparam int T_PWRUP_MS    = 20;

    localparam int RC_CYC     = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WP_CYC     = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WC_CYC     = (T_WC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_CYC    = WC_CYC - WP_CYC;
    localparam int HSB_CYC    = (T_HSB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SS_CYC     = (T_SS_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DELAY_CYC  = (T_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECALL_CYC = (T_RECALL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STORE_CYC  = (T_STORE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PWRUP_CYC  = (T_PWRUP_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Commands and reset levels
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_READ,
        OP_WRITE,
        OP_SW_STORE,
        OP_SW_RECALL,
        OP_HW_STORE
    } nvs_op_t;

    localparam logic [ADDR_W-1:0] ADDR_RST = 17'h00000;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

endpackage

// ### include/nvs_tmr_if.sv
// Interface between the controller sequencer and its down counter.
`timescale 1ns/1ps
`default_nettype none
interface nvs_tmr_if;
    logic                      load;
    logic [nvs_pkg::TMR_W-1:0] value;
    logic                      expired;
    modport ctl (output load, output value, input expired);
    modport tmr (input load, input value, output expired);
endinterface
`default_nettype wire

// ### rtl/nvs_timer.sv
// Shared down counter that times pin cycles and nonvolatile waits.
`timescale 1ns/1ps
`default_nettype none
module nvs_timer #(
    parameter logic [nvs_pkg::TMR_W-1:0] RESET_VAL = 24'h000000
) (
    input  wire logic clock,
    input  wire logic resetn,
    nvs_tmr_if.tmr    t
);
    logic [nvs_pkg::TMR_W-1:0] cnt_r;
    logic [nvs_pkg::TMR_W-1:0] cnt_nxt;

    // Expired looks at the count alone. The sequencer decides its load from
    // this flag, so reading the load back here would close a loop through it.
    assign t.expired = (cnt_r == '0);

    always_comb begin
        cnt_nxt = cnt_r;
        if (t.load) begin
            cnt_nxt = t.value;
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - 24'h000001;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            cnt_r <= RESET_VAL;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule // nvs_timer
`default_nettype wire

// ### rtl/nvs_host.sv
// Host controller that drives the nonvolatile SRAM pins for data and save/restore.
`timescale 1ns/1ps
`default_nettype none
module nvs_host #(
    parameter logic [nvs_pkg::TMR_W-1:0] SS_WAIT     = 24'(nvs_pkg::SS_CYC),
    parameter logic [nvs_pkg::TMR_W-1:0] DELAY_WAIT  = 24'(nvs_pkg::DELAY_CYC),
    parameter logic [nvs_pkg::TMR_W-1:0] RECALL_WAIT = 24'(nvs_pkg::RECALL_CYC),
    parameter logic [nvs_pkg::TMR_W-1:0] STORE_WAIT  = 24'(nvs_pkg::STORE_CYC),
    parameter logic [nvs_pkg::TMR_W-1:0] PWRUP_WAIT  = 24'(nvs_pkg::PWRUP_CYC),
    parameter logic [nvs_pkg::SEQ_LEN-1:0][nvs_pkg::ADDR_W-1:0] STORE_SEQ = {
        17'h00006, 17'h00005, 17'h00004, 17'h00003, 17'h00002, 17'h00001},
    parameter logic [nvs_pkg::SEQ_LEN-1:0][nvs_pkg::ADDR_W-1:0] RECALL_SEQ = {
        17'h00016, 17'h00015, 17'h00014, 17'h00013, 17'h00012, 17'h00011}
) (
    input  wire logic                       clock,
    input  wire logic                       resetn,
    input  wire logic                       cmd_valid,
    output logic                            cmd_ready,
    input  wire nvs_pkg::nvs_op_t           cmd_op,
    input  wire logic [nvs_pkg::ADDR_W-1:0] cmd_addr,
    input  wire logic [nvs_pkg::DATA_W-1:0] cmd_wdata,
    output logic                            rsp_valid,
    output logic [nvs_pkg::DATA_W-1:0]      rsp_rdata,
    output logic [nvs_pkg::ADDR_W-1:0]      nv_addr,
    output logic                            nv_ce_n,
    output logic                            nv_oe_n,
    output logic                            nv_we_n,
    output logic [nvs_pkg::DATA_W-1:0]      nv_dq_o,
    output logic                            nv_dq_oe,
    input  wire logic [nvs_pkg::DATA_W-1:0] nv_dq_i,
    output logic                            hw_save_busy_n_o,
    output logic                            hw_save_busy_n_oe,
    input  wire logic                       hw_save_busy_n_i
);
    // ------------------------------------------------------------------
    // State and timer
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_PWRUP, ST_IDLE, ST_ACC, ST_GAP,
        ST_WAIT_SS, ST_WAIT_NV, ST_HSB_PULSE, ST_HSB_DELAY
    } nvs_state_t;

    nvs_state_t                  state_r, state_nxt;
    nvs_pkg::nvs_op_t            op_r, op_nxt;
    logic                        seq_r, seq_nxt;
    logic [nvs_pkg::IDX_W-1:0]   idx_r, idx_nxt;
    logic                        dirty_r, dirty_nxt;
    logic                        ready_nxt, rsp_nxt;
    logic [nvs_pkg::DATA_W-1:0]  rdata_nxt, dq_o_nxt;
    logic [nvs_pkg::ADDR_W-1:0]  addr_nxt;
    logic                        ce_n_nxt, oe_n_nxt, we_n_nxt, dq_oe_nxt, hsb_oe_nxt;

    nvs_tmr_if tmr ();

    nvs_timer #(
        .RESET_VAL (PWRUP_WAIT)
    ) u_timer (
        .clock  (clock),
        .resetn (resetn),
        .t      (tmr.tmr)
    );

    function automatic logic [nvs_pkg::ADDR_W-1:0] seq_addr(
        input nvs_pkg::nvs_op_t          op,
        input logic [nvs_pkg::IDX_W-1:0] idx
    );
        seq_addr = (op == nvs_pkg::OP_SW_RECALL) ? RECALL_SEQ[idx] : STORE_SEQ[idx];
    endfunction

    // ------------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt  = state_r;
        op_nxt     = op_r;
        seq_nxt    = seq_r;
        idx_nxt    = idx_r;
        dirty_nxt  = dirty_r;
        ready_nxt  = cmd_ready;
        rsp_nxt    = 1'b0;
        rdata_nxt  = rsp_rdata;
        addr_nxt   = nv_addr;
        ce_n_nxt   = nv_ce_n;
        oe_n_nxt   = nv_oe_n;
        we_n_nxt   = nv_we_n;
        dq_o_nxt   = nv_dq_o;
        dq_oe_nxt  = nv_dq_oe;
        hsb_oe_nxt = hw_save_busy_n_oe;
        tmr.load   = 1'b0;
        tmr.value  = '0;
        case (state_r)
            ST_PWRUP: begin
                if (tmr.expired) begin
                    state_nxt = ST_IDLE;
                    ready_nxt = 1'b1;
                end
            end
            ST_IDLE: begin
                if (cmd_valid) begin
                    ready_nxt = 1'b0;
                    op_nxt    = cmd_op;
                    seq_nxt   = 1'b0;
                    tmr.load  = 1'b1;
                    tmr.value = 24'(nvs_pkg::RC_CYC);
                    state_nxt = ST_ACC;
                    case (cmd_op)
                        // reads keep the write strobe high
                        nvs_pkg::OP_READ: begin
                            addr_nxt = cmd_addr;
                            ce_n_nxt = 1'b0;
                            oe_n_nxt = 1'b0;
                            we_n_nxt = 1'b1;
                        end
                        nvs_pkg::OP_WRITE: begin
                            addr_nxt  = cmd_addr;
                            ce_n_nxt  = 1'b0;
                            we_n_nxt  = 1'b0;
                            dq_o_nxt  = cmd_wdata;
                            dq_oe_nxt = 1'b1;
                            dirty_nxt = 1'b1;
                            tmr.value = 24'(nvs_pkg::WP_CYC);
                        end
                        // sequence reads start with write strobe high
                        nvs_pkg::OP_SW_STORE, nvs_pkg::OP_SW_RECALL: begin
                            seq_nxt  = 1'b1;
                            idx_nxt  = nvs_pkg::SEQ_FIRST;
                            addr_nxt = seq_addr(cmd_op, nvs_pkg::SEQ_FIRST);
                            ce_n_nxt = 1'b0;
                            oe_n_nxt = 1'b0;
                            we_n_nxt = 1'b1;
                        end
                        nvs_pkg::OP_HW_STORE: begin
                            hsb_oe_nxt = 1'b1;
                            tmr.value  = 24'(nvs_pkg::HSB_CYC);
                            state_nxt  = ST_HSB_PULSE;
                        end
                        default: begin
                            tmr.load  = 1'b0;
                            ready_nxt = 1'b1;
                            state_nxt = ST_IDLE;
                        end
                    endcase
                end
            end
            // each read lasts at least one read cycle time, each write strobe at least one write pulse width
            ST_ACC: begin
                if (tmr.expired) begin
                    // every access is ended by chip select
                    ce_n_nxt  = 1'b1;
                    oe_n_nxt  = 1'b1;
                    we_n_nxt  = 1'b1;
                    dq_oe_nxt = 1'b0;
                    if (op_r == nvs_pkg::OP_READ) begin
                        rdata_nxt = nv_dq_i;
                    end
                    tmr.load  = 1'b1;
                    tmr.value = 24'(nvs_pkg::GAP_CYC);
                    state_nxt = ST_GAP;
                end
            end
            ST_GAP: begin
                if (tmr.expired) begin
                    if (seq_r && (idx_r != nvs_pkg::SEQ_LAST)) begin
                        // next address of the sequence, no other access between
                        idx_nxt   = idx_r + 3'h1;
                        addr_nxt  = seq_addr(op_r, idx_r + 3'h1);
                        ce_n_nxt  = 1'b0;
                        oe_n_nxt  = 1'b0;
                        tmr.load  = 1'b1;
                        tmr.value = 24'(nvs_pkg::RC_CYC);
                        state_nxt = ST_ACC;
                    end else if (seq_r) begin
                        // wait for the device to act on the command
                        seq_nxt   = 1'b0;
                        tmr.load  = 1'b1;
                        tmr.value = SS_WAIT;
                        state_nxt = ST_WAIT_SS;
                    end else begin
                        rsp_nxt   = 1'b1;
                        ready_nxt = 1'b1;
                        state_nxt = ST_IDLE;
                    end
                end
            end
            ST_WAIT_SS: begin
                if (tmr.expired) begin
                    // a clean array needs no save wait
                    if ((op_r == nvs_pkg::OP_SW_STORE) && !dirty_r) begin
                        rsp_nxt   = 1'b1;
                        ready_nxt = 1'b1;
                        state_nxt = ST_IDLE;
                    end else begin
                        // accesses stay blocked until restore or save ends
                        tmr.load  = 1'b1;
                        tmr.value = (op_r == nvs_pkg::OP_SW_RECALL) ? RECALL_WAIT : STORE_WAIT;
                        state_nxt = ST_WAIT_NV;
                    end
                end
            end
            // restore or save bounded by its longest time
            ST_WAIT_NV: begin
                // released busy line ends the wait early
                if (hw_save_busy_n_i || tmr.expired) begin
                    dirty_nxt = 1'b0;
                    rsp_nxt   = 1'b1;
                    ready_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                end
            end
            ST_HSB_PULSE: begin
                if (tmr.expired) begin
                    hsb_oe_nxt = 1'b0;
                    tmr.load   = 1'b1;
                    tmr.value  = DELAY_WAIT;
                    state_nxt  = ST_HSB_DELAY;
                end
            end
            // give the device its cycle completion window
            ST_HSB_DELAY: begin
                if (tmr.expired) begin
                    if (!dirty_r) begin
                        rsp_nxt   = 1'b1;
                        ready_nxt = 1'b1;
                        state_nxt = ST_IDLE;
                    end else begin
                        tmr.load  = 1'b1;
                        tmr.value = STORE_WAIT;
                        state_nxt = ST_WAIT_NV;
                    end
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                ready_nxt = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_r           <= ST_PWRUP;
            op_r              <= nvs_pkg::OP_READ;
            seq_r             <= 1'b0;
            idx_r             <= nvs_pkg::SEQ_FIRST;
            dirty_r           <= 1'b0;
            cmd_ready         <= 1'b0;
            rsp_valid         <= 1'b0;
            rsp_rdata         <= nvs_pkg::DATA_RST;
            nv_addr           <= nvs_pkg::ADDR_RST;
            nv_ce_n           <= 1'b1;
            nv_oe_n           <= 1'b1;
            nv_we_n           <= 1'b1;
            nv_dq_o           <= nvs_pkg::DATA_RST;
            nv_dq_oe          <= 1'b0;
            hw_save_busy_n_o  <= 1'b0;
            hw_save_busy_n_oe <= 1'b0;
        end else begin
            state_r           <= state_nxt;
            op_r              <= op_nxt;
            seq_r             <= seq_nxt;
            idx_r             <= idx_nxt;
            dirty_r           <= dirty_nxt;
            cmd_ready         <= ready_nxt;
            rsp_valid         <= rsp_nxt;
            rsp_rdata         <= rdata_nxt;
            nv_addr           <= addr_nxt;
            nv_ce_n           <= ce_n_nxt;
            nv_oe_n           <= oe_n_nxt;
            nv_we_n           <= we_n_nxt;
            nv_dq_o           <= dq_o_nxt;
            nv_dq_oe          <= dq_oe_nxt;
            hw_save_busy_n_o  <= 1'b0;
            hw_save_busy_n_oe <= hsb_oe_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    localparam int A_RC = nvs_pkg::RC_CYC;
    localparam logic [nvs_pkg::IDX_W-1:0] A_LAST = nvs_pkg::SEQ_LAST;

    logic [7:0] a_low_cnt;
    always_ff @(posedge clock) begin
        if (!resetn || nv_ce_n) begin
            a_low_cnt <= 8'h00;
        end else begin
            a_low_cnt <= a_low_cnt + 8'h01;
        end
    end

    default clocking a_cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence s_seq_last_end;
        seq_r && (idx_r == A_LAST) && $rose(nv_ce_n);
    endsequence
    sequence s_bus_quiet;
        nv_ce_n [*8];
    endsequence
    sequence s_hsb_release;
        $fell(hw_save_busy_n_oe);
    endsequence

    a_read_we_high: assert property ((!nv_ce_n && !nv_oe_n) |-> nv_we_n)
        else $error("write strobe low during a read");
    a_seq_we_high: assert property (seq_r |-> nv_we_n)
        else $error("write strobe low inside a command sequence");
    a_seq_step: assert property ($changed(idx_r) |-> (idx_r == $past(idx_r) + 3'h1) || (idx_r == 3'h0))
        else $error("sequence index skipped a step");
    a_seq_addr: assert property ((seq_r && !nv_ce_n) |-> (nv_addr == seq_addr(op_r, idx_r)))
        else $error("sequence read at wrong address");
    a_read_width: assert property (($rose(nv_ce_n) && $past(nv_we_n)) |-> ($past(a_low_cnt) >= A_RC))
        else $error("read shorter than the cycle time");
    a_ss_quiet: assert property (s_seq_last_end |-> s_bus_quiet)
        else $error("access right after the sixth sequence read");
    a_hsb_pulse: assert property ($rose(hw_save_busy_n_oe) |-> hw_save_busy_n_oe [*4])
        else $error("save request pulse too short");
    a_hsb_quiet: assert property (!nv_ce_n |-> !hw_save_busy_n_oe)
        else $error("save line driven during an SRAM cycle");
    a_hw_window: assert property (s_hsb_release |-> s_bus_quiet)
        else $error("access inside the hardware save window");
    a_pwr_wait: assert property ((state_r == ST_PWRUP) |-> (nv_ce_n && !cmd_ready))
        else $error("access before power-up restore ended");
    a_nv_block: assert property ((state_r == ST_WAIT_NV) |-> (nv_ce_n && !cmd_ready))
        else $error("access while a nonvolatile cycle runs");
    a_clean_skip: assert property ((state_r == ST_WAIT_SS && tmr.expired && !dirty_r
                                    && op_r == nvs_pkg::OP_SW_STORE) |=> rsp_valid)
        else $error("clean save not completed at once");
    a_busy_poll: assert property ((state_r == ST_WAIT_NV && hw_save_busy_n_i) |=> rsp_valid)
        else $error("released busy line did not end the wait");
endmodule // nvs_host
`default_nettype wire

// ### tb/nvs_dev_model.sv
// Behavioural nonvolatile SRAM that answers the host controller's pins.
`timescale 1ns/1ps
`default_nettype none
module nvs_dev_model #(
    parameter logic [5:0][16:0] SSEQ = '0,
    parameter logic [5:0][16:0] RSEQ = '0
) (
    input  wire logic        clock,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [16:0] addr,
    input  wire logic [7:0]  dq_in,
    output logic [7:0]       dq_out,
    input  wire logic        hw_save_busy_n,
    output logic             busy_oe
);
    logic [7:0]  mem [32];
    logic [7:0]  nv [32];
    logic [7:0]  last_q = 8'h00;
    logic [16:0] a_l = 17'h00000;
    logic        ce_d = 1'b1;
    logic        wlow = 1'b0;
    logic        wr_seen = 1'b0;
    logic        dirty = 1'b0;
    logic        drive;
    int          sidx = 0;
    int          ridx = 0;
    int          busy_cnt = 0;
    int          saves = 0;
    // save copies the whole array, well inside the save bound.
    task automatic do_save();
        nv <= mem;
        dirty <= 1'b0;
        saves <= saves + 1;
        busy_cnt <= 30;
    endtask
    // busy line held low and data locked out.
    assign busy_oe = busy_cnt != 0;
    // data stays undriven when the strobe was low at select.
    assign drive = !ce_n && !oe_n && we_n && !wlow && !busy_oe;
    // A floated bus shows the inverse of its last value, never a friendly repeat.
    assign dq_out = drive ? mem[addr[4:0]] : ~last_q;
    always @(posedge clock) begin
        ce_d <= ce_n;
        if (drive) last_q <= dq_out;
        if (busy_cnt != 0) busy_cnt <= busy_cnt - 1;
        if (ce_d && !ce_n) begin
            wlow <= !we_n;
            a_l <= addr;
            wr_seen <= 1'b0;
        end
        if (!ce_n && !we_n) begin
            mem[addr[4:0]] <= dq_in;
            dirty <= 1'b1;
            wr_seen <= 1'b1;
        end
        // sequence detector advances on clean reads only.
        if (!ce_d && ce_n) begin
            sidx <= wr_seen ? 0 : (a_l == SSEQ[sidx]) ? (sidx + 1) % 6 : int'(a_l == SSEQ[0]);
            ridx <= wr_seen ? 0 : (a_l == RSEQ[ridx]) ? (ridx + 1) % 6 : int'(a_l == RSEQ[0]);
            // commands act after the sixth read.
            if (!wr_seen && sidx == 5 && a_l == SSEQ[5] && dirty) do_save();
            if (!wr_seen && ridx == 5 && a_l == RSEQ[5]) begin
                mem <= nv;
                dirty <= 1'b0;
                busy_cnt <= 20;
            end
        end
        // hardware save request starts a save when dirty.
        if (!hw_save_busy_n && !busy_oe && dirty) do_save();
    end
endmodule // nvs_dev_model
`default_nettype wire

// ### tb/nvs_host_bench.sv
// Self-checking bench for the nonvolatile SRAM host controller.
`timescale 1ns/1ps
`default_nettype none
module nvs_host_bench;
    localparam logic [5:0][16:0] SSEQ = {17'h00006, 17'h00005, 17'h00004,
        17'h00003, 17'h00002, 17'h00001};
    localparam logic [5:0][16:0] RSEQ = {17'h00016, 17'h00015, 17'h00014,
        17'h00013, 17'h00012, 17'h00011};
    typedef struct {nvs_pkg::nvs_op_t op; logic [16:0] a; logic [7:0] d;} nvs_row_t;
    logic             clock = 1'b0;
    logic             resetn = 1'b0;
    logic             cmd_valid = 1'b0;
    logic             cmd_ready, rsp_valid, ce_n, oe_n, we_n, dq_oe, hb_o, hb_oe, dev_oe;
    nvs_pkg::nvs_op_t cmd_op = nvs_pkg::OP_READ;
    logic [16:0]      cmd_addr = 17'h00000;
    logic [16:0]      nv_addr;
    logic [7:0]       cmd_wdata = 8'h00;
    logic [7:0]       rsp_rdata, dq_o, dev_q;
    wire              hw_save_busy_n = !((hb_oe && !hb_o) || dev_oe);
    int               err_total = 0;
    int               n_checks = 0;
    int               s0;
    nvs_row_t         rows [6] = '{'{nvs_pkg::OP_WRITE, 17'h00008, 8'hA5},
        '{nvs_pkg::OP_WRITE, 17'h0001F, 8'h5A}, '{nvs_pkg::OP_WRITE, 17'h00000, 8'h3C},
        '{nvs_pkg::OP_READ, 17'h00008, 8'hA5}, '{nvs_pkg::OP_READ, 17'h0001F, 8'h5A},
        '{nvs_pkg::OP_READ, 17'h00000, 8'h3C}};
    always #2 clock = ~clock;
    nvs_host #(.SS_WAIT(24'h000014), .DELAY_WAIT(24'h000014), .RECALL_WAIT(24'h000028),
        .STORE_WAIT(24'h00003C), .PWRUP_WAIT(24'h00001E), .STORE_SEQ(SSEQ),
        .RECALL_SEQ(RSEQ)) dut (.clock(clock), .resetn(resetn), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .nv_addr(nv_addr), .nv_ce_n(ce_n), .nv_oe_n(oe_n), .nv_we_n(we_n),
        .nv_dq_o(dq_o), .nv_dq_oe(dq_oe), .nv_dq_i(dev_q), .hw_save_busy_n_o(hb_o),
        .hw_save_busy_n_oe(hb_oe), .hw_save_busy_n_i(hw_save_busy_n));
    nvs_dev_model #(.SSEQ(SSEQ), .RSEQ(RSEQ)) dev (.clock(clock), .ce_n(ce_n),
        .oe_n(oe_n), .we_n(we_n), .addr(nv_addr), .dq_in(dq_oe ? dq_o : dev_q),
        .dq_out(dev_q), .hw_save_busy_n(hw_save_busy_n), .busy_oe(dev_oe));
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        n_checks++;
        if (s !== e) begin
            err_total++;
            $display("BAD %0t seen %h wanted %h", $time, s, e);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Requests wait for cmd_ready and for the answer, each under a bound.
    task automatic cmd(input nvs_pkg::nvs_op_t op, input logic [16:0] a, input logic [7:0] d);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 300) begin
            @(posedge clock) #1 n++;
        end
        if (n == 300) chk(8'h01, 8'h00);
        cmd_op    = op;
        cmd_addr  = a;
        cmd_wdata = d;
        cmd_valid = 1'b1;
        @(posedge clock) #1 cmd_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 600) begin
            @(posedge clock) #1 n++;
        end
        if (n == 600) chk(8'h01, 8'h00);
    endtask
    initial begin
        #40000;
        err_total++;
        results();
    end
    initial begin
        repeat (2) @(posedge clock);
        #1 resetn = 1'b1;
        repeat (10) @(posedge clock);
        #1 chk(cmd_ready, 1'b0);
        chk(ce_n, 1'b1);
        $display("reset test done");
        foreach (rows[i]) begin
            cmd(rows[i].op, rows[i].a, rows[i].d);
            if (rows[i].op == nvs_pkg::OP_READ) chk(rsp_rdata, rows[i].d);
        end
        $display("row tests done");
        s0 = dev.saves;
        cmd(nvs_pkg::OP_SW_STORE, 17'h00000, 8'h00);
        chk(8'(dev.saves - s0), 8'h01);
        cmd(nvs_pkg::OP_WRITE, 17'h00008, 8'h11);
        cmd(nvs_pkg::OP_SW_RECALL, 17'h00000, 8'h00);
        cmd(nvs_pkg::OP_READ, 17'h00008, 8'h00);
        chk(rsp_rdata, 8'hA5);
        cmd(nvs_pkg::OP_SW_STORE, 17'h00000, 8'h00);
        chk(8'(dev.saves - s0), 8'h01);
        $display("software command tests done");
        cmd(nvs_pkg::OP_WRITE, 17'h00009, 8'h77);
        cmd(nvs_pkg::OP_HW_STORE, 17'h00000, 8'h00);
        chk(8'(dev.saves - s0), 8'h02);
        cmd(nvs_pkg::OP_WRITE, 17'h00009, 8'h00);
        cmd(nvs_pkg::OP_SW_RECALL, 17'h00000, 8'h00);
        cmd(nvs_pkg::OP_READ, 17'h00009, 8'h00);
        chk(rsp_rdata, 8'h77);
        $display("hardware save test done");
        // A reset in mid-write must release every pin and the save line within two clock edges.
        cmd_op    = nvs_pkg::OP_WRITE;
        cmd_addr  = 17'h00002;
        cmd_wdata = 8'h99;
        cmd_valid = 1'b1;
        @(posedge clock) #1 cmd_valid = 1'b0;
        repeat (3) @(posedge clock);
        #1 resetn = 1'b0;
        repeat (2) @(posedge clock);
        #1 chk({2'b00, we_n, ce_n, oe_n, dq_oe, hb_oe, cmd_ready}, 8'h38);
        resetn = 1'b1;
        repeat (10) @(posedge clock);
        #1 chk(cmd_ready, 1'b0);
        cmd(nvs_pkg::OP_READ, 17'h00009, 8'h00);
        chk(rsp_rdata, 8'h77);
        $display("mid-run reset test done");
        // An undefined operation is taken and leaves the pins idle.
        cmd_op    = nvs_pkg::nvs_op_t'(3'h7);
        cmd_valid = 1'b1;
        @(posedge clock) #1 cmd_valid = 1'b0;
        chk({4'h0, ce_n, hb_oe, cmd_ready, rsp_valid}, 8'h0A);
        $display("undefined operation test done");
        results();
    end
endmodule // nvs_host_bench
`default_nettype wire
